// ===== logic/lhm_pkg.sv
// Shared constants for the limp home mode and input routing block.
// Assumes a single 200 MHz core clock and an APB register port.

package lhm_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned NUM_PORT    = 4;
  localparam int unsigned LIMP_CH     = 4;
  localparam int unsigned SRC_FIELD_W = 3;
  localparam int unsigned SRC_W       = NUM_CH * SRC_FIELD_W;
  localparam int unsigned STS_W       = 2;
  localparam int unsigned PIN_W       = 2 + NUM_PORT;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_ONOFF  = 8'h00;
  localparam logic [7:0] ADDR_SRCSEL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_MODE   = 8'h10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SRC_MODE_BIT   = 2;
  localparam int unsigned SRC_PORT_LSB   = 0;
  localparam int unsigned STS_NOTICE_BIT = 0;
  localparam int unsigned STS_LIMP_BIT   = 1;
  localparam int unsigned MODE_STATE_LSB = 0;
  localparam int unsigned MODE_PORTS_LSB = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NUM_CH-1:0] ONOFF_RST  = 8'h00;
  localparam logic [SRC_W-1:0]  SRCSEL_RST = 24'h000000;
  localparam logic [STS_W-1:0]  STATUS_RST = 2'h0;
  localparam logic [STS_W-1:0]  MASK_RST   = 2'h0;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    LHM_NORMAL,
    LHM_STANDBY,
    LHM_LIMP
  } lhm_state_t;

endpackage : lhm_pkg

// ===== logic/lhm_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent slow level; no bus coherence.
`timescale 1ns/10ps

module lhm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ****************************************************************
  // Stages
  // ****************************************************************
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : lhm_sync

// ===== logic/lhm_mode_router.sv
// Mode control and channel routing for an eight-channel low-side switch.
// Assumes APB master on core_clk_in; pins are asynchronous to it.
//
// Function
// - Power-on reset gives defaults, idle, outputs off
// - Standby pin low holds on/off and source select at defaults
// - Fail-safe high enters limp mode, clears on/off and source select
// - Limp mode routes ports one to four directly
// - Limp mode forces channels five to eight off
// - Serial traffic ignored while in limp mode; the code refuses writes with an error and still answers reads
// - Fail-safe beats standby when both requested
// - Fail-safe during standby wakes into limp mode
// - Fail-safe fall clears on/off and source select, standby or idle
// - Leaving limp mode sets the reset notice flag
// - Source select picks direct port per channel
// - Input mode: port level acts as on/off
// - Serial mode: on/off bit drives the channel
// - Open port reads low, channel goes off
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

module lhm_mode_router (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        fail_safe_request_in,
  input  wire logic        standby_request_n_in,
  input  wire logic [3:0]  direct_control_port_in,
  output logic      [7:0]  power_channel_out,
  output logic             irq_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [lhm_pkg::PIN_W-1:0]  pins_sync;
  logic                       fs_s;
  logic                       sb_n_s;
  logic [lhm_pkg::NUM_PORT-1:0] dcp_s;
  lhm_pkg::lhm_state_t        state_ff;
  lhm_pkg::lhm_state_t        nxt_state;
  logic                       regs_clear;
  logic                       wr_en;
  logic                       rd_setup;
  logic                       addr_ok;
  logic [lhm_pkg::NUM_CH-1:0] onoff_ff;
  logic [lhm_pkg::NUM_CH-1:0] nxt_onoff;
  logic [lhm_pkg::SRC_W-1:0]  srcsel_ff;
  logic [lhm_pkg::SRC_W-1:0]  nxt_srcsel;
  logic [lhm_pkg::STS_W-1:0]  status_ff;
  logic [lhm_pkg::STS_W-1:0]  nxt_status;
  logic [lhm_pkg::STS_W-1:0]  mask_ff;
  logic [lhm_pkg::STS_W-1:0]  nxt_mask;
  logic [31:0]                prdata_ff;
  logic [31:0]                nxt_prdata;
  logic [lhm_pkg::NUM_CH-1:0] out_ff;
  logic [lhm_pkg::NUM_CH-1:0] nxt_out;
  logic [lhm_pkg::NUM_CH-1:0] norm_drive;
  logic                       notice_ev;
  logic                       limp_ev;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic ch_level(
    input logic                              req,
    input logic [lhm_pkg::SRC_FIELD_W-1:0]   src,
    input logic [lhm_pkg::NUM_PORT-1:0]      ports
  );
    logic [1:0] idx;
    idx = src[lhm_pkg::SRC_PORT_LSB +: 2];
    if (src[lhm_pkg::SRC_MODE_BIT]) begin
      return ports[idx];
    end
    return req;
  endfunction : ch_level

  function automatic logic is_wr(input logic [7:0] addr, input logic [7:0] want,
                                 input logic en);
    return en && (addr == want);
  endfunction : is_wr

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Open ports sink low off-chip; low maps to off with no inversion
  // Standby level crosses inverted, so flop reset reads as no request
  lhm_sync #(
    .W (lhm_pkg::PIN_W)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    ({fail_safe_request_in, ~standby_request_n_in, direct_control_port_in}),
    .sync_out    (pins_sync)
  );

  assign fs_s   = pins_sync[lhm_pkg::PIN_W-1];
  assign sb_n_s = ~pins_sync[lhm_pkg::PIN_W-2];
  assign dcp_s  = pins_sync[lhm_pkg::NUM_PORT-1:0];

  // ****************************************************************
  // Mode control
  // ****************************************************************
  always_comb begin
    nxt_state = lhm_pkg::LHM_NORMAL;
    if (fs_s) begin
      nxt_state = lhm_pkg::LHM_LIMP;
    end else if (!sb_n_s) begin
      nxt_state = lhm_pkg::LHM_STANDBY;
    end
    // Any stay outside normal, and the exit edge itself, clears config
    regs_clear = (state_ff != lhm_pkg::LHM_NORMAL) ||
                 (nxt_state != lhm_pkg::LHM_NORMAL);
    notice_ev  = (state_ff == lhm_pkg::LHM_LIMP) &&
                 (nxt_state != lhm_pkg::LHM_LIMP);
    limp_ev    = (state_ff != lhm_pkg::LHM_LIMP) &&
                 (nxt_state == lhm_pkg::LHM_LIMP);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= lhm_pkg::LHM_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // APB slave and registers
  // ****************************************************************
  assign pready_out = 1'b1;
  assign rd_setup   = psel_in && !penable_in;
  assign addr_ok    = (paddr_in == lhm_pkg::ADDR_ONOFF)  ||
                      (paddr_in == lhm_pkg::ADDR_SRCSEL) ||
                      (paddr_in == lhm_pkg::ADDR_STATUS) ||
                      (paddr_in == lhm_pkg::ADDR_MASK)   ||
                      (paddr_in == lhm_pkg::ADDR_MODE);
  // Writes only land in normal mode
  assign wr_en = psel_in && penable_in && pwrite_in &&
                 (state_ff == lhm_pkg::LHM_NORMAL);
  // Refused writes flag an error instead of vanishing silently
  assign pslverr_out = psel_in && penable_in &&
                       (!addr_ok || (pwrite_in && (state_ff != lhm_pkg::LHM_NORMAL)));

  always_comb begin
    nxt_onoff  = onoff_ff;
    nxt_srcsel = srcsel_ff;
    nxt_mask   = mask_ff;
    nxt_status = status_ff;
    if (regs_clear) begin
      nxt_onoff  = lhm_pkg::ONOFF_RST;
      nxt_srcsel = lhm_pkg::SRCSEL_RST;
    end else begin
      if (is_wr(paddr_in, lhm_pkg::ADDR_ONOFF, wr_en)) begin
        nxt_onoff = pwdata_in[lhm_pkg::NUM_CH-1:0];
      end
      if (is_wr(paddr_in, lhm_pkg::ADDR_SRCSEL, wr_en)) begin
        nxt_srcsel = pwdata_in[lhm_pkg::SRC_W-1:0];
      end
    end
    if (is_wr(paddr_in, lhm_pkg::ADDR_MASK, wr_en)) begin
      nxt_mask = pwdata_in[lhm_pkg::STS_W-1:0];
    end
    if (is_wr(paddr_in, lhm_pkg::ADDR_STATUS, wr_en)) begin
      nxt_status = status_ff & ~pwdata_in[lhm_pkg::STS_W-1:0];
    end
    // Set after clear so a coincident event survives
    if (notice_ev) begin
      nxt_status[lhm_pkg::STS_NOTICE_BIT] = 1'b1;
    end
    if (limp_ev) begin
      nxt_status[lhm_pkg::STS_LIMP_BIT] = 1'b1;
    end
  end

  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      nxt_prdata = 32'h00000000;
      unique case (paddr_in)
        lhm_pkg::ADDR_ONOFF:  nxt_prdata[lhm_pkg::NUM_CH-1:0] = onoff_ff;
        lhm_pkg::ADDR_SRCSEL: nxt_prdata[lhm_pkg::SRC_W-1:0]  = srcsel_ff;
        lhm_pkg::ADDR_STATUS: nxt_prdata[lhm_pkg::STS_W-1:0]  = status_ff;
        lhm_pkg::ADDR_MASK:   nxt_prdata[lhm_pkg::STS_W-1:0]  = mask_ff;
        lhm_pkg::ADDR_MODE: begin
          nxt_prdata[lhm_pkg::MODE_STATE_LSB +: 2] = state_ff;
          nxt_prdata[lhm_pkg::MODE_PORTS_LSB +: lhm_pkg::NUM_PORT] = dcp_s;
        end
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      onoff_ff  <= lhm_pkg::ONOFF_RST;
      srcsel_ff <= lhm_pkg::SRCSEL_RST;
      status_ff <= lhm_pkg::STATUS_RST;
      mask_ff   <= lhm_pkg::MASK_RST;
      prdata_ff <= 32'h00000000;
    end else begin
      onoff_ff  <= nxt_onoff;
      srcsel_ff <= nxt_srcsel;
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_out = prdata_ff;
  assign irq_out    = |(status_ff & mask_ff);

  // ****************************************************************
  // Output routing
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < lhm_pkg::NUM_CH; i++) begin
      norm_drive[i] = ch_level(onoff_ff[i],
                               srcsel_ff[i*lhm_pkg::SRC_FIELD_W +: lhm_pkg::SRC_FIELD_W],
                               dcp_s);
    end
    nxt_out = '0;
    unique case (state_ff)
      lhm_pkg::LHM_NORMAL:  nxt_out = norm_drive;
      lhm_pkg::LHM_STANDBY: nxt_out = '0;
      lhm_pkg::LHM_LIMP: begin
        nxt_out[lhm_pkg::LIMP_CH-1:0] = dcp_s;
        nxt_out[lhm_pkg::NUM_CH-1:lhm_pkg::LIMP_CH] = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign power_channel_out = out_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_limp_entry;
    fs_s |=> (state_ff == lhm_pkg::LHM_LIMP);
  endproperty
  a_limp_entry: assert property (p_limp_entry)
    else $error("fail-safe did not enter limp mode");

  property p_fs_priority;
    (fs_s && !sb_n_s) |=> (state_ff == lhm_pkg::LHM_LIMP) ##1
      (power_channel_out[7:4] == 4'h0);
  endproperty
  a_fs_priority: assert property (p_fs_priority)
    else $error("standby overrode fail-safe");

  property p_limp_route;
    (state_ff == lhm_pkg::LHM_LIMP) |=> (power_channel_out[3:0] == $past(dcp_s));
  endproperty
  a_limp_route: assert property (p_limp_route)
    else $error("limp routing wrong on low channels");

  property p_limp_high_off;
    (state_ff == lhm_pkg::LHM_LIMP) [*2] |-> (power_channel_out[7:4] == 4'h0);
  endproperty
  a_limp_high_off: assert property (p_limp_high_off)
    else $error("high channel on in limp mode");

  property p_limp_ignore;
    (state_ff == lhm_pkg::LHM_LIMP) && psel_in && penable_in && pwrite_in |->
      pslverr_out ##1 (onoff_ff == lhm_pkg::ONOFF_RST);
  endproperty
  a_limp_ignore: assert property (p_limp_ignore)
    else $error("write accepted in limp mode");

  property p_regs_clear;
    (state_ff != lhm_pkg::LHM_NORMAL) |=>
      (onoff_ff == lhm_pkg::ONOFF_RST) && (srcsel_ff == lhm_pkg::SRCSEL_RST);
  endproperty
  a_regs_clear: assert property (p_regs_clear)
    else $error("registers not at defaults after mode change");

  property p_notice;
    (state_ff == lhm_pkg::LHM_LIMP) && !fs_s |=>
      status_ff[lhm_pkg::STS_NOTICE_BIT] && (state_ff != lhm_pkg::LHM_LIMP);
  endproperty
  a_notice: assert property (p_notice)
    else $error("reset notice not set on limp exit");

  property p_standby_off;
    (state_ff == lhm_pkg::LHM_STANDBY) |=> (power_channel_out == 8'h00);
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("output on during standby");

  property p_normal_drive;
    (state_ff == lhm_pkg::LHM_NORMAL) |=> (power_channel_out == $past(norm_drive));
  endproperty
  a_normal_drive: assert property (p_normal_drive)
    else $error("normal mode output mismatch");

  property p_irq;
    !wr_en && ((limp_ev && mask_ff[lhm_pkg::STS_LIMP_BIT]) ||
               (notice_ev && mask_ff[lhm_pkg::STS_NOTICE_BIT])) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing");

  c_limp:    cover property ((state_ff == lhm_pkg::LHM_LIMP) ##1 !fs_s);
  c_notice:  cover property ($rose(status_ff[lhm_pkg::STS_NOTICE_BIT]));
  c_standby: cover property (state_ff == lhm_pkg::LHM_STANDBY);
  c_input:   cover property ((state_ff == lhm_pkg::LHM_NORMAL) &&
                             srcsel_ff[lhm_pkg::SRC_MODE_BIT] && norm_drive[0]);

endmodule : lhm_mode_router

// ===== verification/lhm_host_model.sv
// Host model: APB master and the control pins of the microcontroller.
// Assumes the router samples on core_clk_in rising edges.
`timescale 1ns/10ps

module lhm_host_model (
  input  wire logic        core_clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [7:0]  paddr_out,
  output logic      [31:0] pwdata_out,
  output logic             fail_safe_request_out,
  output logic             standby_request_n_out,
  output logic      [3:0]  direct_control_port_out
);
  initial begin
    psel_out                = 1'b0;
    penable_out             = 1'b0;
    pwrite_out              = 1'b0;
    paddr_out               = 8'hA5;
    pwdata_out              = 32'h5A5A5A5A;
    fail_safe_request_out   = 1'b0;
    standby_request_n_out   = 1'b1;
    direct_control_port_out = 4'h0;
  end

  // ****************************************************************
  // Bus cycle
  // ****************************************************************
  // Source select writes go through here as ordinary words
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] rdata, output logic err);
    @(posedge core_clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= wr;
    paddr_out   <= addr;
    pwdata_out  <= data;
    @(posedge core_clk_in);
    penable_out <= 1'b1;
    @(posedge core_clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge core_clk_in);
    end
    rdata = prdata_in;
    err   = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // Released lines must not keep stale values
    paddr_out   <= ~addr;
    pwdata_out  <= ~data;
  endtask : apb

  task automatic pins(input logic fs, input logic stb_n, input logic [3:0] ports);
    @(posedge core_clk_in);
    fail_safe_request_out   <= fs;
    standby_request_n_out   <= stb_n;
    direct_control_port_out <= ports;
  endtask : pins
endmodule : lhm_host_model

// ===== verification/tb.sv
// Self-checking bench for the mode router.
// Assumes the host model drives every router input except clock and reset.
`timescale 1ns/10ps

module tb;
  typedef struct packed {
    logic [7:0]  onoff;
    logic [23:0] src;
    logic [3:0]  ports;
    logic [7:0]  out;
  } lhm_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, fs, stb_n, irq;
  logic [7:0]  paddr, chan;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ports;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  lhm_row_t    rows [5] = '{'{8'hA5, 24'h000000, 4'h0, 8'hA5},
                            '{8'h00, 24'hE00004, 4'h9, 8'h81},
                            '{8'h00, 24'hE00004, 4'h0, 8'h00},
                            '{8'hFF, 24'h000030, 4'h0, 8'hFD},
                            '{8'h00, 24'h000030, 4'h4, 8'h02}};

  always #2.5 clk = ~clk;

  lhm_mode_router i_lhm_mode_router (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .fail_safe_request_in(fs),
    .standby_request_n_in(stb_n), .direct_control_port_in(ports),
    .power_channel_out(chan), .irq_out(irq));

  lhm_host_model u_host (
    .core_clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .fail_safe_request_out(fs), .standby_request_n_out(stb_n),
    .direct_control_port_out(ports));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write checks ready and the error flag; a read checks data too
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    u_host.apb(wr, a, d, rd, err);
    check({31'h0, pready}, 32'h00000001);
    check({31'h0, err}, {31'h0, exp_err});
    if (!wr) begin
      check(rd, exp);
    end
  endtask : acc

  // Pin path is 2 sync edges, a state edge and an output edge
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  function automatic logic [31:0] mode(input logic [3:0] p, input lhm_pkg::lhm_state_t s);
    return {24'h0, p, 2'b00, s};
  endfunction : mode

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({24'h0, chan}, 32'h0);
    acc(0, lhm_pkg::ADDR_ONOFF, 0, 0, 0);
    acc(0, lhm_pkg::ADDR_SRCSEL, 0, 0, 0);
    acc(0, lhm_pkg::ADDR_STATUS, 0, 0, 0);
    acc(0, lhm_pkg::ADDR_MASK, 0, 0, 0);
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h0, lhm_pkg::LHM_NORMAL), 0);
    acc(0, 8'h14, 0, 0, 1);
    $display("test reset done");
    foreach (rows[i]) begin
      u_host.pins(1'b0, 1'b1, rows[i].ports);
      acc(1, lhm_pkg::ADDR_ONOFF, {24'h0, rows[i].onoff}, 0, 0);
      acc(1, lhm_pkg::ADDR_SRCSEL, {8'h0, rows[i].src}, 0, 0);
      settle();
      check({24'h0, chan}, {24'h0, rows[i].out});
    end
    $display("test routing rows done");
    acc(1, lhm_pkg::ADDR_ONOFF, 32'hFF, 0, 0);
    acc(1, lhm_pkg::ADDR_SRCSEL, 0, 0, 0);
    acc(1, lhm_pkg::ADDR_MASK, 32'h3, 0, 0);
    u_host.pins(1'b1, 1'b1, 4'h5);
    settle();
    check({24'h0, chan}, 32'h05);
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h5, lhm_pkg::LHM_LIMP), 0);
    acc(0, lhm_pkg::ADDR_ONOFF, 0, 0, 0);
    acc(1, lhm_pkg::ADDR_ONOFF, 32'hFF, 0, 1);
    acc(0, lhm_pkg::ADDR_STATUS, 0, 32'h2, 0);
    check({31'h0, irq}, 32'h1);
    u_host.pins(1'b0, 1'b1, 4'h5);
    settle();
    check({24'h0, chan}, 32'h0);
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h5, lhm_pkg::LHM_NORMAL), 0);
    acc(0, lhm_pkg::ADDR_STATUS, 0, 32'h3, 0);
    acc(1, lhm_pkg::ADDR_STATUS, 32'h3, 0, 0);
    acc(0, lhm_pkg::ADDR_STATUS, 0, 0, 0);
    check({31'h0, irq}, 32'h0);
    $display("test limp done");
    acc(1, lhm_pkg::ADDR_MASK, 0, 0, 0);
    acc(1, lhm_pkg::ADDR_ONOFF, 32'hFF, 0, 0);
    u_host.pins(1'b0, 1'b0, 4'h5);
    settle();
    check({24'h0, chan}, 32'h0);
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h5, lhm_pkg::LHM_STANDBY), 0);
    acc(0, lhm_pkg::ADDR_ONOFF, 0, 0, 0);
    acc(1, lhm_pkg::ADDR_ONOFF, 32'hFF, 0, 1);
    u_host.pins(1'b1, 1'b0, 4'h5);
    settle();
    check({24'h0, chan}, 32'h05);
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h5, lhm_pkg::LHM_LIMP), 0);
    u_host.pins(1'b0, 1'b0, 4'h5);
    settle();
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h5, lhm_pkg::LHM_STANDBY), 0);
    acc(0, lhm_pkg::ADDR_STATUS, 0, 32'h3, 0);
    check({31'h0, irq}, 32'h0);
    u_host.pins(1'b0, 1'b1, 4'h0);
    settle();
    acc(0, lhm_pkg::ADDR_MODE, 0, mode(4'h0, lhm_pkg::LHM_NORMAL), 0);
    check({24'h0, chan}, 32'h0);
    $display("test standby done");
    acc(1'b1, lhm_pkg::ADDR_ONOFF, 32'h000000FF, 32'h00000000, 1'b0);
    settle();
    check({24'h0, chan}, 32'h000000FF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({24'h0, chan}, 32'h00000000);
    rst_n <= 1'b1;
    @(posedge clk);
    check({24'h0, chan}, 32'h00000000);
    acc(1'b0, lhm_pkg::ADDR_ONOFF, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, lhm_pkg::ADDR_STATUS, 32'h0, 32'h00000000, 1'b0);
    acc(1'b0, lhm_pkg::ADDR_MODE, 32'h0, mode(4'h0, lhm_pkg::LHM_NORMAL), 1'b0);
    $display("test second reset done");
    summarize();
  end
endmodule : tb
